//--- core/tap_pkg.sv
// How it works
// - Controller walks the sixteen standard states on each sampled TCK rise using TMS.
// - Only TCK, TMS, TDI, TDO; power-on reset puts the controller in Test-Logic-Reset.
// - Shared pin carries the key signal in Test-Logic-Reset, otherwise TDO.
// - IR states shift the instruction register; DR states shift the selected register.
// - Three-bit instruction register, no parity, captures 101.
// - Codes 000 and 001 put the boundary chain in the serial path.
// - Code 010 puts the 32-bit identification register in the path.
// - Codes 100 to 111 select the one-bit bypass register.
// - After reset the identification register, not bypass, is selected.
// - Identification word: version, part number, maker code, bit zero one.
// - Maker field holds only the seven low maker bits, no parity.
// - Code 011 selects the 8-bit test-mode register: shift and update, no capture.
// - Test-mode register cleared on power-on reset.
// - Boundary chain is 38 cells at the pins.
// - Input cell captures pin, shifts, ignores update.
// - Output cell captures, shifts, and copies capture stage to update stage on update.
// - Under EXTEST and CLAMP pins follow update stages, under HIGHZ enables are off, otherwise system values.
// - Four cells steer group output enables between system and scanned values.
// - Pixel clock pin uses one input cell plus one enable cell.
package tap_pkg;
  localparam int N_IN = 13;
  localparam int N_OUT = 21;
  localparam int N_EN = 4;
  localparam int N_BSR = N_IN + N_OUT + N_EN;
  localparam int OUT_LSB = N_IN;
  localparam int EN_LSB = N_IN + N_OUT;
  localparam int PIX_CELL = 0;
  localparam int PIX_EN_GRP = 0;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int TM_W = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h5;
  localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] OP_SAMPLE = 3'h1;
  localparam logic [IR_W-1:0] OP_IDCODE = 3'h2;
  localparam logic [IR_W-1:0] OP_TESTMODE = 3'h3;
  localparam logic [IR_W-1:0] OP_HIGHZ = 3'h4;
  localparam logic [IR_W-1:0] OP_CLAMP = 3'h6;
  localparam logic [TM_W-1:0] TM_RESET = 8'h00;
  localparam logic ID_FIXED_LSB = 1'h1;
  localparam logic [3:0] ID_BANK = 4'h0;

  typedef enum logic [3:0] {
    TLR = 4'hf, RTI = 4'hc, SEL_DR = 4'h7, CAP_DR = 4'h6,
    SH_DR = 4'h2, EX1_DR = 4'h1, PA_DR = 4'h3, EX2_DR = 4'h0,
    UPD_DR = 4'h5, SEL_IR = 4'h4, CAP_IR = 4'he, SH_IR = 4'ha,
    EX1_IR = 4'h9, PA_IR = 4'hb, EX2_IR = 4'h8, UPD_IR = 4'hd
  } tap_state_e;

  typedef enum logic [1:0] {
    SEL_BSR = 2'h0, SEL_ID = 2'h1, SEL_BYP = 2'h2, SEL_TM = 2'h3
  } dr_sel_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_s;

  typedef struct packed {
    logic [N_EN-1:0] oe;
    logic [N_OUT-1:0] dout;
  } out_pins_s;
endpackage

//--- core/tap_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tap_sync
  import tap_pkg::*;
#(
  parameter logic INIT = 1'h0
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_regs_s;

  sync_regs_s r;
  sync_regs_s next_r;

  // Level moves only when the second and third stages agree
  always_comb
  begin
    next_r.s1 = i_async;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.lvl = (r.s2 == r.s3) ? r.s2 : r.lvl;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      r <= {INIT, INIT, INIT, INIT};
    else
      r <= next_r;
  end

  assign o_level = r.lvl;
endmodule
`default_nettype wire

//--- core/boundary_cell.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_cell
  import tap_pkg::*;
#(
  parameter bit HAS_UPDATE = 1'b0
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_capture,
  input wire logic i_shift,
  input wire logic i_update,
  input wire logic i_sys,
  input wire logic i_scan,
  output logic o_cap,
  output logic o_upd
);
  typedef struct packed {
    logic cap;
    logic upd;
  } cell_regs_s;

  cell_regs_s r;
  cell_regs_s next_r;

  always_comb
  begin
    next_r = r;
    if (i_capture)
      next_r.cap = i_sys;
    else if (i_shift)
      next_r.cap = i_scan;
    if (i_update && HAS_UPDATE)
      next_r.upd = r.cap;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign o_cap = r.cap;
  assign o_upd = r.upd;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_input_no_upd: assert property (!HAS_UPDATE |-> !o_upd)
    else $error("input cell update stage moved");
  chk_update_copy: assert property (HAS_UPDATE && i_update |=> o_upd == $past(o_cap))
    else $error("output cell update stage did not copy capture stage");
endmodule
`default_nettype wire

//--- core/boundary_scan_tap.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap
  import tap_pkg::*;
#(
  parameter logic [3:0] ID_VERSION = 4'h2,
  parameter logic [15:0] ID_PART = 16'h1234,
  parameter logic [6:0] ID_MAKER = 7'h15
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire jtag_s i_jtag,
  input wire logic i_alpha,
  output logic o_key_tdo_pin,
  output logic o_key_tdo_oe,
  input wire logic [N_IN-2:0] i_pin_in,
  input wire out_pins_s i_sys,
  output out_pins_s o_pins,
  input wire logic i_pixel_clock_pin_in,
  input wire logic i_pixel_clock_sys,
  output logic o_pixel_clock_pin_out,
  output logic o_pixel_clock_pin_oe,
  output logic [TM_W-1:0] o_test_mode
);
  // ID_VERSION, ID_PART and ID_MAKER defaults are arbitrary values
  localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_BANK, ID_MAKER, ID_FIXED_LSB};

  typedef struct packed {
    tap_state_e st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [TM_W-1:0] tm_sh;
    logic [TM_W-1:0] tm;
    logic tdo;
    logic tdo_en;
    logic tck_d;
  } tap_regs_s;

  tap_regs_s r;
  tap_regs_s next_r;

  logic tck;
  logic tms;
  logic tdi;
  logic rise;
  logic fall;
  dr_sel_e sel;
  logic dr_out;
  logic bsr_capture;
  logic bsr_shift;
  logic bsr_update;
  logic scan_drive;
  logic [N_BSR-1:0] bsr_sys;
  logic [N_BSR-1:0] bsr_cap;
  logic [N_BSR-1:0] bsr_upd;
  logic [N_BSR-1:0] bsr_chain_in;

  // ==========================================================
  // Pin sampling
  // ==========================================================
  // TMS idles high so a quiet port stays in reset
  tap_sync #(.INIT(1'h0)) u_sync_tck
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_jtag.tck),
    .o_level(tck)
  );

  tap_sync #(.INIT(1'h1)) u_sync_tms
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_jtag.tms),
    .o_level(tms)
  );

  tap_sync #(.INIT(1'h0)) u_sync_tdi
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_jtag.tdi),
    .o_level(tdi)
  );

  // TMS and TDI share the TCK latency, so they are stable at the found edge
  assign rise = tck && !r.tck_d;
  assign fall = !tck && r.tck_d;

  // ==========================================================
  // Controller
  // ==========================================================
  function automatic tap_state_e tap_next(input tap_state_e s, input logic m);
    unique case (s)
      TLR: tap_next = m ? TLR : RTI;
      RTI: tap_next = m ? SEL_DR : RTI;
      SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = m ? EX1_DR : SH_DR;
      SH_DR: tap_next = m ? EX1_DR : SH_DR;
      EX1_DR: tap_next = m ? UPD_DR : PA_DR;
      PA_DR: tap_next = m ? EX2_DR : PA_DR;
      EX2_DR: tap_next = m ? UPD_DR : SH_DR;
      UPD_DR: tap_next = m ? SEL_DR : RTI;
      SEL_IR: tap_next = m ? TLR : CAP_IR;
      CAP_IR: tap_next = m ? EX1_IR : SH_IR;
      SH_IR: tap_next = m ? EX1_IR : SH_IR;
      EX1_IR: tap_next = m ? UPD_IR : PA_IR;
      PA_IR: tap_next = m ? EX2_IR : PA_IR;
      EX2_IR: tap_next = m ? UPD_IR : SH_IR;
      UPD_IR: tap_next = m ? SEL_IR : RTI;
    endcase
  endfunction

  // Bypass owns every code with the top bit set
  always_comb
  begin
    if (r.ir == OP_EXTEST || r.ir == OP_SAMPLE)
      sel = SEL_BSR;
    else if (r.ir == OP_IDCODE)
      sel = SEL_ID;
    else if (r.ir == OP_TESTMODE)
      sel = SEL_TM;
    else
      sel = SEL_BYP;
  end

  always_comb
  begin
    unique case (sel)
      SEL_BSR: dr_out = bsr_cap[0];
      SEL_ID: dr_out = r.id_sh[0];
      SEL_BYP: dr_out = r.byp;
      SEL_TM: dr_out = r.tm_sh[0];
    endcase
  end

  always_comb
  begin
    next_r = r;
    next_r.tck_d = tck;
    if (rise)
    begin
      next_r.st = tap_next(r.st, tms);
      if (r.st == CAP_IR)
        next_r.ir_sh = IR_CAPTURE;
      if (r.st == SH_IR)
        next_r.ir_sh = {tdi, r.ir_sh[IR_W-1:1]};
      if (r.st == CAP_DR && sel == SEL_BYP)
        next_r.byp = 1'b0;
      if (r.st == CAP_DR && sel == SEL_ID)
        next_r.id_sh = ID_VALUE;
      if (r.st == SH_DR)
      begin
        // Test-mode shifter has no capture, so it returns the last word
        unique case (sel)
          SEL_BSR: ;
          SEL_ID: next_r.id_sh = {tdi, r.id_sh[ID_W-1:1]};
          SEL_BYP: next_r.byp = tdi;
          SEL_TM: next_r.tm_sh = {tdi, r.tm_sh[TM_W-1:1]};
        endcase
      end
    end
    if (fall)
    begin
      // TDO changes on the falling edge, half a TCK ahead of the sampler
      next_r.tdo_en = (r.st == SH_IR) || (r.st == SH_DR);
      next_r.tdo = (r.st == SH_IR) ? r.ir_sh[0] : dr_out;
      if (r.st == UPD_IR)
        next_r.ir = r.ir_sh;
      // Loading it may wedge the chip; nothing here blocks the tester
      if (r.st == UPD_DR && sel == SEL_TM)
        next_r.tm = r.tm_sh;
    end
    if (r.st == TLR)
      next_r.ir = OP_IDCODE;
  end

  // Power-on reset is the only reset: no test reset pin exists
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r <= '0;
      r.st <= TLR;
      r.ir <= OP_IDCODE;
      r.tm <= TM_RESET;
      r.tm_sh <= TM_RESET;
    end
    else
      r <= next_r;
  end

  // ==========================================================
  // Boundary chain
  // ==========================================================
  assign bsr_capture = rise && r.st == CAP_DR && sel == SEL_BSR;
  assign bsr_shift = rise && r.st == SH_DR && sel == SEL_BSR;
  assign bsr_update = fall && r.st == UPD_DR && sel == SEL_BSR;
  assign bsr_sys = {i_sys.oe, i_sys.dout, i_pin_in, i_pixel_clock_pin_in};
  assign bsr_chain_in = {tdi, bsr_cap[N_BSR-1:1]};

  for (genvar i = 0; i < N_BSR; i++)
  begin : g_cell
    boundary_cell #(.HAS_UPDATE(i >= OUT_LSB)) u_cell
    (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_capture(bsr_capture),
      .i_shift(bsr_shift),
      .i_update(bsr_update),
      .i_sys(bsr_sys[i]),
      .i_scan(bsr_chain_in[i]),
      .o_cap(bsr_cap[i]),
      .o_upd(bsr_upd[i])
    );
  end

  // ==========================================================
  // Pin muxes
  // ==========================================================
  assign scan_drive = (r.ir == OP_EXTEST) || (r.ir == OP_CLAMP);

  always_comb
  begin
    o_pins.dout = scan_drive ? bsr_upd[EN_LSB-1:OUT_LSB] : i_sys.dout;
    if (r.ir == OP_HIGHZ)
      o_pins.oe = '0;
    else if (scan_drive)
      o_pins.oe = bsr_upd[N_BSR-1:EN_LSB];
    else
      o_pins.oe = i_sys.oe;
  end

  // Pixel clock data has no output cell, only its group enable is scanned
  assign o_pixel_clock_pin_out = i_pixel_clock_sys;
  assign o_pixel_clock_pin_oe = o_pins.oe[PIX_EN_GRP];

  // Board hazard: chips fed from this pin cannot be scanned through it in reset
  assign o_key_tdo_pin = (r.st == TLR) ? i_alpha : r.tdo;
  assign o_key_tdo_oe = (r.st == TLR) || r.tdo_en;
  assign o_test_mode = r.tm;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_tms_holds_reset: assert property (rise && r.st == TLR && tms |=> r.st == TLR)
    else $error("controller left reset with TMS high");
  chk_state_on_edge: assert property (!rise |=> $stable(r.st))
    else $error("controller moved without a TCK rise");
  chk_key_in_reset: assert property (r.st == TLR |-> o_key_tdo_pin == i_alpha && o_key_tdo_oe)
    else $error("key signal missing in reset state");
  chk_tdo_idle_off: assert property (fall && r.st == RTI |=> !o_key_tdo_oe)
    else $error("TDO driven outside shift");
  chk_ir_capture: assert property (rise && r.st == CAP_IR |=> r.ir_sh == IR_CAPTURE)
    else $error("wrong instruction capture pattern");
  chk_reset_idcode: assert property (r.st == TLR |=> r.ir == OP_IDCODE && sel == SEL_ID)
    else $error("identification not selected after reset");
  chk_id_capture: assert property (rise && r.st == CAP_DR && sel == SEL_ID |=> r.id_sh == ID_VALUE)
    else $error("identification word not captured");
  chk_bypass_path: assert property (fall && r.st == SH_DR && sel == SEL_BYP |=> r.tdo == $past(r.byp))
    else $error("bypass bit not on TDO");
  chk_bsr_path: assert property (fall && r.st == SH_DR && sel == SEL_BSR |=> r.tdo == $past(bsr_cap[0]))
    else $error("boundary chain not on TDO");
  chk_tm_no_capture: assert property (rise && r.st == CAP_DR && sel == SEL_TM |=> $stable(r.tm_sh))
    else $error("test-mode shifter captured");
  chk_extest_drive: assert property (r.ir == OP_EXTEST |-> o_pins.dout == bsr_upd[EN_LSB-1:OUT_LSB])
    else $error("pins not driven from update stages");
  chk_highz_float: assert property (r.ir == OP_HIGHZ |-> o_pins.oe == '0 && sel == SEL_BYP)
    else $error("outputs enabled under high impedance");

  // ==========================================================
  // Path and select checks
  // ==========================================================
  chk_idle_to_select: assert property (rise && r.st == RTI && tms |=> r.st == SEL_DR)
    else $error("idle did not move to data select");
  chk_shift_stays: assert property (rise && r.st == SH_DR && !tms |=> r.st == SH_DR)
    else $error("data shift left with TMS low");
  chk_ir_exit_reset: assert property (rise && r.st == SEL_IR && tms |=> r.st == TLR)
    else $error("instruction select did not reach reset");
  chk_tdo_pin_out: assert property (r.st != TLR |-> o_key_tdo_pin == r.tdo)
    else $error("shared pin not carrying TDO");
  chk_tdo_on_shift: assert property (fall && (r.st == SH_IR || r.st == SH_DR) |=> o_key_tdo_oe)
    else $error("TDO not driven in shift");
  chk_tdo_off_exit: assert property (fall && r.st == EX1_DR |=> !o_key_tdo_oe)
    else $error("TDO still driven after shift");
  chk_ir_path: assert property (fall && r.st == SH_IR |=> r.tdo == $past(r.ir_sh[0]))
    else $error("instruction bit not on TDO");
  chk_ir_update: assert property (fall && r.st == UPD_IR |=> r.ir == $past(r.ir_sh))
    else $error("instruction not updated");
  chk_ir_shift_in: assert property (rise && r.st == SH_IR |=> r.ir_sh[IR_W-1] == $past(tdi))
    else $error("TDI not shifted into instruction");
  chk_ir_stable: assert property (!(fall && r.st == UPD_IR) && r.st != TLR |=> $stable(r.ir))
    else $error("instruction changed outside update");
  chk_bsr_select: assert property ((r.ir == OP_EXTEST || r.ir == OP_SAMPLE) |-> sel == SEL_BSR)
    else $error("boundary chain not selected");
  chk_bypass_codes: assert property (r.ir[IR_W-1] |-> sel == SEL_BYP)
    else $error("upper codes not on bypass");
  chk_tm_select: assert property (r.ir == OP_TESTMODE |-> sel == SEL_TM)
    else $error("test-mode register not selected");
  chk_bypass_capture: assert property (rise && r.st == CAP_DR && sel == SEL_BYP |=> !r.byp)
    else $error("bypass did not capture zero");
  chk_byp_shift: assert property (rise && r.st == SH_DR && sel == SEL_BYP |=> r.byp == $past(tdi))
    else $error("bypass did not take TDI");
  chk_id_path: assert property (fall && r.st == SH_DR && sel == SEL_ID |=> r.tdo == $past(r.id_sh[0]))
    else $error("identification bit not on TDO");
  chk_id_shift: assert property (rise && r.st == SH_DR && sel == SEL_ID |=> r.id_sh[ID_W-1] == $past(tdi))
    else $error("TDI not shifted into identification");
  chk_tm_path: assert property (fall && r.st == SH_DR && sel == SEL_TM |=> r.tdo == $past(r.tm_sh[0]))
    else $error("test-mode bit not on TDO");
  chk_tm_shift: assert property (rise && r.st == SH_DR && sel == SEL_TM |=> r.tm_sh[TM_W-1] == $past(tdi))
    else $error("TDI not shifted into test-mode");
  chk_tm_update: assert property (fall && r.st == UPD_DR && sel == SEL_TM |=> o_test_mode == $past(r.tm_sh))
    else $error("test-mode register not updated");
  chk_tm_hold: assert property (!(fall && r.st == UPD_DR && sel == SEL_TM) |=> $stable(o_test_mode))
    else $error("test-mode register changed outside update");
  chk_clamp_drive: assert property (r.ir == OP_CLAMP |-> o_pins == bsr_upd[N_BSR-1:OUT_LSB])
    else $error("clamp not driven from update stages");
  chk_system_pins: assert property (!scan_drive && r.ir != OP_HIGHZ |-> o_pins == i_sys)
    else $error("system values not on pins");
  chk_sample_no_drive: assert property (r.ir == OP_SAMPLE |-> o_pins.dout == i_sys.dout)
    else $error("sample drove pins from scan");
  chk_bsr_capture: assert property (bsr_capture |=> bsr_cap == $past(bsr_sys))
    else $error("boundary chain did not capture pins");
  chk_bsr_shift: assert property (bsr_shift |=> bsr_cap == $past(bsr_chain_in))
    else $error("boundary chain did not shift");
  chk_bsr_update: assert property (bsr_update |=> bsr_upd[N_BSR-1:OUT_LSB] == $past(bsr_cap[N_BSR-1:OUT_LSB]))
    else $error("output cells did not update");
  chk_input_upd_idle: assert property (bsr_update |=> bsr_upd[OUT_LSB-1:0] == '0)
    else $error("input cells acted on update");

  cov_leave_reset: cover property (r.st == TLR ##1 r.st == RTI);
  cov_extest_load: cover property (r.st == UPD_IR && fall ##1 r.ir == OP_EXTEST);
  cov_tm_update: cover property (r.st == UPD_DR && fall && sel == SEL_TM);
  cov_id_shift: cover property (r.st == SH_DR && sel == SEL_ID && rise);
  cov_bsr_update: cover property (r.st == UPD_DR && fall && sel == SEL_BSR);
endmodule
`default_nettype wire

//--- core/README_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tb/jtag_tester.sv
`timescale 1ns/1ps
`default_nettype none
module jtag_tester
  import tap_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_tdo,
  output jtag_s o_jtag
);
  // ==========================================================
  // Link drive
  // TCK stands low between frames; TMS/TDI only move while TCK is low,
  // half a link period away from the rising edge the block samples
  initial o_jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};

  task automatic half();
    repeat (20) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_jtag.tms = tms;
    o_jtag.tdi = tdi;
    half();
    tdo = i_tdo;
    o_jtag.tck = 1'b1;
    half();
    o_jtag.tck = 1'b0;
  endtask

  // Outside shifts TDI carries the inverse of its last value, never a stale one
  task automatic go(input logic tms);
    logic d;
    step(tms, ~o_jtag.tdi, d);
  endtask

  // Five TMS high rises reach reset from any state, then park in idle
  task automatic to_idle();
    repeat (5) go(1'b1);
    go(1'b0);
  endtask

  // Shift one register from idle back to idle, LSB first
  task automatic scan(input logic ir, input int width, input logic [79:0] din, output logic [79:0] dout);
    logic b;
    dout = '0;
    go(1'b1);
    if (ir)
    begin
      go(1'b1);
    end
    go(1'b0);
    go(1'b0);
    for (int i = 0; i < width; i++)
    begin
      step(i == width - 1, din[i], b);
      dout[i] = b;
    end
    go(1'b1);
    go(1'b0);
  endtask
endmodule
`default_nettype wire

//--- tb/test_boundary_scan_tap.sv
`timescale 1ns/1ps
`default_nettype none
module test_boundary_scan_tap
  import tap_pkg::*;
;
  // Identification fields are arbitrary values
  localparam logic [3:0] VER = 4'h9;
  localparam logic [15:0] PART = 16'h5a3c;
  localparam logic [6:0] MAKER = 7'h2b;
  logic i_sys_clk;
  logic i_rst_n;
  jtag_s jtag;
  logic alpha;
  logic pin;
  logic pin_oe;
  logic [N_IN-2:0] pin_in;
  out_pins_s sys;
  out_pins_s pins;
  logic pix_in;
  logic pix_sys;
  logic pix_out;
  logic pix_oe;
  logic [TM_W-1:0] test_mode;
  int error_cnt;
  int n_tests;
  int seed;
  logic [79:0] d;
  logic [79:0] q;
  logic [79:0] upd;

  boundary_scan_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) boundary_scan_tap_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_jtag(jtag), .i_alpha(alpha),
    .o_key_tdo_pin(pin), .o_key_tdo_oe(pin_oe), .i_pin_in(pin_in), .i_sys(sys), .o_pins(pins),
    .i_pixel_clock_pin_in(pix_in), .i_pixel_clock_sys(pix_sys), .o_pixel_clock_pin_out(pix_out),
    .o_pixel_clock_pin_oe(pix_oe), .o_test_mode(test_mode)
  );

  // Pull-up on the shared pin: an undriven pin reads high at the tester
  jtag_tester jtag_tester_inst (.i_sys_clk(i_sys_clk), .i_tdo(pin_oe ? pin : 1'b1), .o_jtag(jtag));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  // ==========================================================
  // Checking helpers
  task automatic check(input string name, input logic [79:0] exp, input logic [79:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [79:0] id_word();
    return {48'h0, VER, PART, 4'h0, MAKER, 1'b1};
  endfunction

  // Cell 0 is the pixel clock input, then input pins, outputs, enables
  function automatic logic [79:0] cap_vec();
    return {42'h0, sys, pin_in, pix_in};
  endfunction

  function automatic logic [79:0] rnd80();
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    return r[79:0];
  endfunction

  task automatic stim();
    @(posedge i_sys_clk);
    #1;
    d = rnd80();
    pin_in = d[N_IN-2:0];
    sys = d[40:16];
    pix_in = d[50];
    pix_sys = d[51];
  endtask

  task automatic load(input logic [IR_W-1:0] code);
    logic [79:0] r;
    jtag_tester_inst.scan(1'b1, IR_W, {77'h0, code}, r);
    check("ir_capture", {77'h0, IR_CAPTURE}, r);
  endtask

  task automatic alpha_check(input logic exp_follow);
    logic old;
    old = pin;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_sys_clk);
      #1;
      alpha = ~alpha;
      @(posedge i_sys_clk);
      #1;
      check("key_pin", {79'h0, exp_follow ? alpha : old}, {79'h0, pin});
      check("key_oe", {79'h0, exp_follow}, {79'h0, pin_oe});
    end
  endtask

  initial
  begin
    #300000;
    error_cnt++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 55;
    error_cnt = 0;
    n_tests = 0;
    i_rst_n = 1'b0;
    alpha = 1'b0;
    pin_in = '0;
    sys = '0;
    pix_in = 1'b0;
    pix_sys = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    alpha_check(1'b1);
    check("test_mode_rst", 80'h0, {72'h0, test_mode});
    jtag_tester_inst.to_idle();
    alpha_check(1'b0);
    jtag_tester_inst.scan(1'b0, ID_W, rnd80(), q);
    check("id_after_reset", id_word(), q);
    load(OP_IDCODE);
    jtag_tester_inst.scan(1'b0, ID_W, rnd80(), q);
    check("id_loaded", id_word(), q);
    for (int c = 4; c < 8; c++)
    begin
      stim();
      load(c[IR_W-1:0]);
      if (c == 4)
      begin
        check("highz_oe", 80'h0, {76'h0, pins.oe});
        check("highz_dout", {59'h0, sys.dout}, {59'h0, pins.dout});
        check("pix_oe", 80'h0, {79'h0, pix_oe});
      end
      jtag_tester_inst.scan(1'b0, 2, d, q);
      check("bypass", {78'h0, d[0], 1'b0}, q);
    end
    for (int c = 1; c >= 0; c--)
    begin
      stim();
      load(c[IR_W-1:0]);
      d = rnd80();
      jtag_tester_inst.scan(1'b0, 2 * N_BSR, d, q);
      check("bsr_capture", cap_vec(), {42'h0, q[37:0]});
      check("bsr_length", {42'h0, d[37:0]}, {42'h0, q[75:38]});
      upd = {55'h0, d[75:51]};
      check("pins", c == 1 ? {55'h0, sys} : upd, {55'h0, pins});
      check("pix_oe", {79'h0, c == 1 ? sys.oe[PIX_EN_GRP] : upd[N_OUT + PIX_EN_GRP]}, {79'h0, pix_oe});
      check("pix_out", {79'h0, pix_sys}, {79'h0, pix_out});
    end
    stim();
    load(OP_CLAMP);
    check("clamp_pins", upd, {55'h0, pins});
    // The only TESTMODE instruction load of the run; two scans load the register, the power-on reset below clears it
    load(OP_TESTMODE);
    jtag_tester_inst.scan(1'b0, TM_W, d, q);
    check("tm_first", 80'h0, q);
    check("tm_update", {72'h0, d[7:0]}, {72'h0, test_mode});
    upd = rnd80() | 80'h1;
    jtag_tester_inst.scan(1'b0, TM_W, upd, q);
    check("tm_echo", {72'h0, d[7:0]}, q);
    repeat (5) jtag_tester_inst.go(1'b1);
    alpha_check(1'b1);
    jtag_tester_inst.go(1'b0);
    jtag_tester_inst.scan(1'b0, ID_W, rnd80(), q);
    check("id_after_tlr", id_word(), q);
    // Power-on reset in mid-frame must drop test mode and return to reset state
    jtag_tester_inst.go(1'b1);
    i_rst_n = 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    check("tm_por", 80'h0, {72'h0, test_mode});
    alpha_check(1'b1);
    jtag_tester_inst.to_idle();
    jtag_tester_inst.scan(1'b0, ID_W, rnd80(), q);
    check("id_after_por", id_word(), q);
    finish_test();
  end
endmodule
`default_nettype wire
